/* File: alu_slice_params.svh */
// Purpose: constants for the microcoded 16-bit alu slice
// Assumes: one 25 MHz clock, apb register access
// Notes: offsets are byte addresses of aligned 32-bit words
`ifndef ALU_SLICE_PARAMS_SVH
`define ALU_SLICE_PARAMS_SVH

// apb register offsets
`define REG_CTRL_OFS 12'h000
`define REG_STAT_OFS 12'h004
`define REG_RESULT_OFS 12'h008
`define REG_ACCUM_OFS 12'h00c

// control register fields and reset values
`define CTRL_RUN_BIT 0
`define CTRL_RESET 1'b0
`define STATUS_RESET 8'h00
`define WORD_RESET 16'h0000

// status register bit positions
`define STAT_ZERO 0
`define STAT_CARRY 1
`define STAT_NEG 2
`define STAT_OVR 3
`define STAT_LINK 4
`define STAT_FLAG1 5
`define STAT_FLAG2 6
`define STAT_FLAG3 7

// timing: half microcycle and clock period in ns
`define HALF_CYCLE_NS 100
`define CLK_PERIOD_NS 40

`endif

/* File: alu_slice_pkg.sv */
// Purpose: types shared by the alu slice and its bench
// Assumes: op codes are the enum order, taken from instruction bits {14:13,8:5}
// Notes: codes beyond the last op behave as no-operation
package alu_slice_pkg;

  typedef enum logic [5:0] {
    OP_NOP, OP_MOVE, OP_COMP, OP_NEG, OP_INC, OP_ADD, OP_ADDC, OP_SUB,
    OP_SUBC, OP_AND, OP_NAND, OP_OR, OP_NOR, OP_XOR, OP_XNOR, OP_SHUP,
    OP_SHDN, OP_PRIO, OP_CRC, OP_SETST, OP_RSTST, OP_SETBIT, OP_RSTBIT, OP_ADDP2,
    OP_SUBP2, OP_ROTL, OP_ROTMRG, OP_ROTCMP, OP_TSTBIT, OP_SAVEST, OP_LOADST, OP_TESTST
  } op_t;

  typedef enum logic [1:0] {SRC_RIN, SRC_ACC, SRC_LATCH} rot_src_t;

  typedef enum logic [1:0] {CIN_ZERO, CIN_ONE, CIN_CARRY} cin_sel_t;

  // control word fields from the microsequencer
  typedef struct packed {
    rot_src_t rot_src;
    logic b_from_acc;
    cin_sel_t cin_sel;
    logic dst_rin;
    logic dst_acc;
    logic wr_alt;
    logic [4:0] wr_addr;
  } ctrl_t;

  typedef struct packed {
    logic flag3;
    logic flag2;
    logic flag1;
    logic link;
    logic overflow_flag;
    logic neg;
    logic carry;
    logic zero;
  } status_t;

endpackage : alu_slice_pkg

/* File: alu_slice.sv */
// Purpose: microcoded 16-bit alu slice with halfword and byte modes
// Assumes: instruction, control word and y bus valid in the first half microcycle
// Notes: registers reached over apb; rule summary follows
// Summary of operation
// - every alu result drives the y bus in the second half.
// - upper eight y bits are unspecified for byte operations.
// - internal store is single-port 32 by 16 ram with output latch.
// - store writes bits 7:0 in byte mode, all sixteen in halfword.
// - store takes separate read and write addresses in one instruction.
// - edge-triggered accumulator loads low byte in byte mode, all otherwise.
// - data latch captures y bus at every microcycle midpoint.
// - rotator turns store, accumulator or latch 0 to 15 places, 0 to 7 in byte mode.
// - alu gives moves, arithmetic, logic, rotate-merge and rotate-compare.
// - carry in comes from mux of zero, one or stored carry.
// - priority encoder gives index of top set bit after masking.
// - status updates after every instruction except nop, save, test status.
// - status bits hold zero, carry, negative, overflow, link, three flags.
// - upper status bits change only by own set/reset or halfword load; link also by shifts.
// - every shift also updates the link bit.
// - status loads from and reads onto y; byte load touches four flags.
// - twelve condition signals from status go to branch condition mux.
// - shifts, crc, prioritize and status set/reset ignore the count field.
// - instruction fields 4:0, 8:5, 12:9, 15:13; bit 15 selects halfword.
// - byte mode operations work only on operand bits 7:0.
//
// Decided for this implementation: register access over APB and the address map.
`include "alu_slice_params.svh"

module alu_slice #(
  parameter int WORD_W = 16,
  parameter int RIN_DEPTH = 32
) (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // microsequencer control
  input wire logic [15:0] I_INSTR,
  input wire alu_slice_pkg::ctrl_t I_CTRL,
  // y bus
  input wire logic [15:0] I_Y,
  output logic [15:0] O_Y,
  output logic O_Y_OE_N,
  // timing and conditions
  output logic O_SECOND_HALF,
  output logic O_CYCLE_END,
  output logic [11:0] O_COND
);
  import alu_slice_pkg::*;

  localparam int HALF_STEPS = `HALF_CYCLE_NS / `CLK_PERIOD_NS;
  localparam logic [2:0] LAST_STEP = 3'(HALF_STEPS - 1);

  ////////////////////////////////////////////////////////////////////////////
  // microcycle timing
  logic run_reg;
  logic [2:0] step_reg;
  logic half_reg;
  logic mid_edge;
  logic end_edge;

  assign mid_edge = run_reg && !half_reg && (step_reg == LAST_STEP);
  assign end_edge = run_reg && half_reg && (step_reg == LAST_STEP);

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      step_reg <= 3'h0;
      half_reg <= 1'b0;
    end else if (run_reg) begin
      if (step_reg == LAST_STEP) begin
        step_reg <= 3'h0;
        half_reg <= !half_reg;
      end else begin
        step_reg <= step_reg + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // first half capture: instruction, control word, data latch, store latch
  logic [15:0] instr_reg;
  ctrl_t ctrl_reg;
  logic [WORD_W-1:0] latch_reg;
  logic [WORD_W-1:0] rin_latch_reg;
  logic [WORD_W-1:0] rin_mem [RIN_DEPTH];

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      instr_reg <= 16'h0000;
      ctrl_reg <= '0;
      latch_reg <= `WORD_RESET;
      rin_latch_reg <= `WORD_RESET;
    end else if (mid_edge) begin
      instr_reg <= I_INSTR;
      ctrl_reg <= I_CTRL;
      latch_reg <= I_Y;
      rin_latch_reg <= rin_mem[I_INSTR[4:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction fields
  logic byte_mode;
  logic [3:0] cnt_n;
  logic [5:0] op_code;
  op_t op;

  assign byte_mode = !instr_reg[15];
  assign cnt_n = instr_reg[12:9];
  assign op_code = {instr_reg[14:13], instr_reg[8:5]};
  assign op = (op_code <= 6'(OP_TESTST)) ? op_t'(op_code) : OP_NOP;

  ////////////////////////////////////////////////////////////////////////////
  // barrel rotator and operands
  status_t status_reg;
  logic [WORD_W-1:0] acc_reg;
  logic [WORD_W-1:0] rot_in;
  logic [3:0] rot_amt;
  logic [31:0] rot_wide;
  logic [15:0] rot_byte;
  logic [WORD_W-1:0] a;
  logic [WORD_W-1:0] b;
  logic [WORD_W-1:0] m;
  logic cin;

  always_comb begin
    case (ctrl_reg.rot_src)
      SRC_RIN: rot_in = rin_latch_reg;
      SRC_ACC: rot_in = acc_reg;
      default: rot_in = latch_reg;
    endcase
  end

  // count field only turns the rotator for rotate ops
  assign rot_amt = (op == OP_ROTL || op == OP_ROTMRG || op == OP_ROTCMP) ? cnt_n : 4'h0;
  assign rot_wide = {rot_in, rot_in} << rot_amt;
  assign rot_byte = {rot_in[7:0], rot_in[7:0]} << rot_amt[2:0];
  assign a = byte_mode ? {rot_in[15:8], rot_byte[15:8]} : rot_wide[31:16];
  assign b = ctrl_reg.b_from_acc ? acc_reg : latch_reg;
  assign m = latch_reg;

  always_comb begin
    case (ctrl_reg.cin_sel)
      CIN_ZERO: cin = 1'b0;
      CIN_ONE: cin = 1'b1;
      default: cin = status_reg.carry;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // alu function
  logic [WORD_W-1:0] res;
  logic [WORD_W-1:0] add_a;
  logic [WORD_W-1:0] add_b;
  logic add_c;
  logic use_add;
  logic shift_op;
  logic shift_c;
  logic [WORD_W-1:0] pow;
  logic [WORD_W-1:0] pin;
  logic [WORD_W-1:0] crc_sh;
  logic [16:0] sum;
  logic [8:0] sum_lo;
  logic msb_a;
  logic fb;
  integer i;

  assign pow = 16'(16'h0001 << cnt_n);
  assign pin = byte_mode ? {8'h00, a[7:0] & m[7:0]} : (a & m);
  assign msb_a = byte_mode ? a[7] : a[15];
  assign fb = a[0] ^ status_reg.carry;
  assign crc_sh = byte_mode ? {a[15:8], 1'b0, a[7:1]} : {1'b0, a[15:1]};
  assign sum = {1'b0, add_a} + {1'b0, add_b} + {16'h0000, add_c};
  assign sum_lo = {1'b0, add_a[7:0]} + {1'b0, add_b[7:0]} + {8'h00, add_c};

  always_comb begin
    res = a;
    add_a = a;
    add_b = 16'h0000;
    add_c = 1'b0;
    use_add = 1'b0;
    shift_op = 1'b0;
    shift_c = 1'b0;
    case (op)
      OP_COMP: res = ~a;
      OP_NEG: begin
        add_a = ~a;
        add_c = 1'b1;
        use_add = 1'b1;
      end
      OP_INC: begin
        add_b = 16'h0001;
        use_add = 1'b1;
      end
      OP_ADD: begin
        add_b = b;
        use_add = 1'b1;
      end
      OP_ADDC: begin
        add_b = b;
        add_c = cin;
        use_add = 1'b1;
      end
      OP_SUB: begin
        add_b = ~b;
        add_c = 1'b1;
        use_add = 1'b1;
      end
      OP_SUBC: begin
        add_b = ~b;
        add_c = cin;
        use_add = 1'b1;
      end
      OP_AND: res = a & b;
      OP_NAND: res = ~(a & b);
      OP_OR: res = a | b;
      OP_NOR: res = ~(a | b);
      OP_XOR: res = a ^ b;
      OP_XNOR: res = ~(a ^ b);
      OP_SHUP: begin
        res = byte_mode ? {a[15:8], a[6:0], cin} : {a[14:0], cin};
        shift_op = 1'b1;
        shift_c = msb_a;
      end
      OP_SHDN: begin
        res = byte_mode ? {a[15:8], cin, a[7:1]} : {cin, a[15:1]};
        shift_op = 1'b1;
        shift_c = a[0];
      end
      OP_PRIO: begin
        res = 16'h0000;
        for (i = 0; i < WORD_W; i = i + 1) begin
          if (pin[i]) begin
            res = 16'(i);
          end
        end
      end
      OP_CRC: begin
        res = fb ? (crc_sh ^ m) : crc_sh;
        shift_c = fb;
      end
      OP_SETBIT: res = a | pow;
      OP_RSTBIT: res = a & ~pow;
      OP_ADDP2: begin
        add_b = pow;
        use_add = 1'b1;
      end
      OP_SUBP2: begin
        add_b = ~pow;
        add_c = 1'b1;
        use_add = 1'b1;
      end
      OP_ROTMRG: res = (a & m) | (acc_reg & ~m);
      OP_ROTCMP: res = (a ^ acc_reg) & m;
      OP_TSTBIT: res = a & pow;
      OP_SAVEST: res = {8'h00, status_reg};
      OP_TESTST: res = {8'h00, status_reg};
      OP_LOADST: res = m;
      default: res = a;
    endcase
    if (use_add) begin
      res = sum[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status next value
  status_t st_next;
  logic res_msb;
  logic res_zero;
  logic add_carry;
  logic add_ovr;
  logic msb_b;
  logic msb_aa;

  assign res_msb = byte_mode ? res[7] : res[15];
  assign res_zero = byte_mode ? (res[7:0] == 8'h00) : (res == 16'h0000);
  assign add_carry = byte_mode ? sum_lo[8] : sum[16];
  assign msb_aa = byte_mode ? add_a[7] : add_a[15];
  assign msb_b = byte_mode ? add_b[7] : add_b[15];
  assign add_ovr = (msb_aa == msb_b) && (res_msb != msb_aa);

  always_comb begin
    st_next = status_reg;
    case (op)
      OP_NOP, OP_SAVEST, OP_TESTST: st_next = status_reg;
      OP_LOADST: begin
        if (byte_mode) begin
          st_next[3:0] = m[3:0];
        end else begin
          st_next = m[7:0];
        end
      end
      OP_SETST, OP_RSTST: begin
        st_next[instr_reg[2:0]] = (op == OP_SETST);
      end
      default: begin
        st_next.zero = res_zero;
        st_next.neg = res_msb;
        st_next.carry = use_add ? add_carry : shift_c;
        st_next.overflow_flag = use_add ? add_ovr : 1'b0;
        if (shift_op) begin
          st_next.link = shift_c;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // end of microcycle: store, accumulator and status commit
  logic [4:0] wr_addr;
  logic [WORD_W-1:0] result_reg;

  assign wr_addr = ctrl_reg.wr_alt ? ctrl_reg.wr_addr : instr_reg[4:0];

  always_ff @(posedge I_CLK) begin
    if (end_edge && ctrl_reg.dst_rin) begin
      rin_mem[wr_addr][7:0] <= res[7:0];
      if (!byte_mode) begin
        rin_mem[wr_addr][15:8] <= res[15:8];
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      acc_reg <= `WORD_RESET;
    end else if (end_edge && ctrl_reg.dst_acc) begin
      acc_reg[7:0] <= res[7:0];
      if (!byte_mode) begin
        acc_reg[15:8] <= res[15:8];
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      status_reg <= `STATUS_RESET;
      result_reg <= `WORD_RESET;
    end else if (end_edge) begin
      status_reg <= st_next;
      result_reg <= res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // y bus drive and timing outputs
  assign O_Y = res;
  assign O_Y_OE_N = !half_reg;
  assign O_SECOND_HALF = half_reg;
  assign O_CYCLE_END = end_edge;

  // branch condition mux inputs
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_COND <= 12'h000;
    end else begin
      O_COND[0] <= (status_reg.neg ^ status_reg.overflow_flag) | status_reg.zero;
      O_COND[1] <= status_reg.neg ^ status_reg.overflow_flag;
      O_COND[2] <= status_reg.zero;
      O_COND[3] <= status_reg.overflow_flag;
      O_COND[4] <= 1'b0;
      O_COND[5] <= status_reg.carry;
      O_COND[6] <= status_reg.zero | !status_reg.carry;
      O_COND[7] <= status_reg.neg;
      O_COND[8] <= status_reg.link;
      O_COND[9] <= status_reg.flag1;
      O_COND[10] <= status_reg.flag2;
      O_COND[11] <= status_reg.flag3;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  logic apb_setup;
  logic apb_write;
  logic addr_ok;
  logic [31:0] rd_mux;

  assign apb_setup = I_PSEL && !I_PENABLE;
  assign apb_write = I_PSEL && I_PENABLE && I_PWRITE;
  assign O_PREADY = 1'b1;

  always_comb begin
    addr_ok = 1'b1;
    case (I_PADDR)
      `REG_CTRL_OFS: rd_mux = {31'h00000000, run_reg};
      `REG_STAT_OFS: rd_mux = {24'h000000, status_reg};
      `REG_RESULT_OFS: rd_mux = {16'h0000, result_reg};
      `REG_ACCUM_OFS: rd_mux = {16'h0000, acc_reg};
      default: begin
        rd_mux = 32'h00000000;
        addr_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_PRDATA <= 32'h00000000;
      O_PSLVERR <= 1'b0;
    end else if (apb_setup) begin
      O_PRDATA <= I_PWRITE ? 32'h00000000 : rd_mux;
      O_PSLVERR <= !addr_ok;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      run_reg <= `CTRL_RESET;
    end else if (apb_write && I_PADDR == `REG_CTRL_OFS) begin
      run_reg <= I_PWDATA[`CTRL_RUN_BIT];
    end
  end

endmodule : alu_slice

/* File: alu_slice_props.sv */
// Purpose: concurrent checks on the alu slice ports
// Assumes: one clock, reset active low
// Notes: bound to every alu_slice instance
module alu_slice_props (
  // clock and reset
  input wire logic I_CLK,
  input wire logic I_NRST,
  // apb
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic [31:0] O_PRDATA,
  input wire logic O_PREADY,
  input wire logic O_PSLVERR,
  // datapath
  input wire logic [15:0] O_Y,
  input wire logic O_Y_OE_N,
  input wire logic O_SECOND_HALF,
  input wire logic O_CYCLE_END,
  input wire logic [11:0] O_COND
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_NRST);
  AST_Y_DRIVE: assert property (O_Y_OE_N == !O_SECOND_HALF)
    else $error("y drive not in second half");
  AST_END_LATE: assert property (O_CYCLE_END |-> O_SECOND_HALF && $past(O_SECOND_HALF))
    else $error("cycle end outside late second half");
  AST_END_PULSE: assert property (O_CYCLE_END |=> (!O_CYCLE_END) [*3])
    else $error("cycle end too close");
  AST_Y_STANDS: assert property (O_SECOND_HALF && $past(O_SECOND_HALF) |-> $stable(O_Y))
    else $error("result moved in second half");
  AST_COND_LAG: assert property ($changed(O_COND) && $past(I_NRST, 2) |-> $past(O_CYCLE_END, 2))
    else $error("conditions changed without commit");
  AST_COND_MIX: assert property (O_COND[1] == (O_COND[7] ^ O_COND[3])
    && O_COND[0] == (O_COND[1] | O_COND[2]))
    else $error("signed conditions inconsistent");
  AST_COND_CARRY: assert property ($past(I_NRST) |-> O_COND[6] == (O_COND[2] | !O_COND[5]) && !O_COND[4])
    else $error("carry conditions inconsistent");
  AST_ERR_ZERO: assert property (I_PSEL && I_PENABLE && O_PSLVERR |-> O_PRDATA == 32'h0 && O_PREADY)
    else $error("error read not zero");
  C_END: cover property (O_CYCLE_END);
  C_ERR: cover property (I_PSEL && I_PENABLE && O_PSLVERR);
  C_LINK: cover property (O_COND[8]);
endmodule : alu_slice_props

bind alu_slice alu_slice_props u_props (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL),
  .I_PENABLE(I_PENABLE), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR),
  .O_Y(O_Y), .O_Y_OE_N(O_Y_OE_N), .O_SECOND_HALF(O_SECOND_HALF), .O_CYCLE_END(O_CYCLE_END),
  .O_COND(O_COND));

/* File: alu_slice_seq.sv */
// Purpose: microsequencer and y bus source facing the slice
// Assumes: new word taken at each microcycle end
// Notes: y bus level resolved from both drivers
module alu_slice_seq (
  // clock, reset and cycle end
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_end,
  // requested word
  input wire logic [15:0] i_instr,
  input wire alu_slice_pkg::ctrl_t i_ctrl,
  input wire logic [15:0] i_y,
  // slice side
  input wire logic [15:0] i_y_dut,
  input wire logic i_oe_n,
  output logic [15:0] o_instr,
  output alu_slice_pkg::ctrl_t o_ctrl,
  output logic [15:0] o_y
);
  import alu_slice_pkg::*;
  logic [15:0] y_reg;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_instr <= 16'h0000;
      o_ctrl <= '0;
      y_reg <= 16'h0000;
    end else if (i_end) begin
      o_instr <= i_instr;
      o_ctrl <= i_ctrl;
      y_reg <= i_y;
    end
  end
  assign o_y = i_oe_n ? y_reg : i_y_dut;
endmodule : alu_slice_seq

/* File: alu_slice_tb.sv */
// Purpose: self-checking bench for the alu slice
// Assumes: zero wait apb, four clock microcycle
// Notes: model of store, accumulator and status
`include "alu_slice_params.svh"
module alu_slice_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import alu_slice_pkg::*;
  logic I_CLK = 1'b0;
  logic I_NRST = 1'b0;
  logic I_PSEL = 1'b0;
  logic I_PENABLE = 1'b0;
  logic I_PWRITE = 1'b0;
  logic [11:0] I_PADDR = 12'h000;
  logic [31:0] I_PWDATA = 32'h0;
  logic [31:0] O_PRDATA;
  logic O_PREADY, O_PSLVERR, O_Y_OE_N, O_SECOND_HALF, O_CYCLE_END;
  logic [15:0] I_INSTR, I_Y, O_Y, nx_i, nx_y, acc, lr;
  logic [15:0] internal_register_store [32];
  logic [11:0] O_COND, pcm;
  logic [7:0] st;
  logic [31:0] rd;
  logic er;
  ctrl_t I_CTRL, nx_c;
  int n_errors, checks;
  always #20 I_CLK = ~I_CLK;
  alu_slice dut (.I_CLK(I_CLK), .I_NRST(I_NRST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_INSTR(I_INSTR), .I_CTRL(I_CTRL),
    .I_Y(I_Y), .O_Y(O_Y), .O_Y_OE_N(O_Y_OE_N), .O_SECOND_HALF(O_SECOND_HALF),
    .O_CYCLE_END(O_CYCLE_END), .O_COND(O_COND));
  alu_slice_seq seq (.i_clk(I_CLK), .i_nrst(I_NRST), .i_end(O_CYCLE_END), .i_instr(nx_i),
    .i_ctrl(nx_c), .i_y(nx_y), .i_y_dut(O_Y), .i_oe_n(O_Y_OE_N), .o_instr(I_INSTR),
    .o_ctrl(I_CTRL), .o_y(I_Y));
  ////////////////////////////////////////
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task complete_run;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  function automatic logic [11:0] cf(logic [7:0] s);
    return {s[7:4], s[2], s[0] | ~s[1], s[1], 1'b0, s[3], s[0], s[2] ^ s[3], (s[2] ^ s[3]) | s[0]};
  endfunction : cf
  task apb(input bit w, input logic [11:0] ad, input logic [31:0] d);
    int t;
    @(posedge I_CLK);
    I_PSEL <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE <= w;
    I_PADDR <= ad;
    I_PWDATA <= d;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    t = 0;
    do @(posedge I_CLK); while (O_PREADY !== 1'b1 && ++t < 50);
    rd = O_PRDATA;
    er = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask : apb
  ////////////////////////////////////////
  task automatic exe(op_t op, bit hw, logic [3:0] n, rot_src_t rs, bit ba, cin_sel_t cs,
                     bit da, bit dr, logic [4:0] ra, logic [4:0] wa, logic [15:0] y);
    logic [15:0] a, b, m;
    logic [31:0] t;
    logic [16:0] s;
    logic ci;
    int w;
    m = hw ? 16'hffff : 16'h00ff;
    w = hw ? 15 : 7;
    nx_i = {hw, op[5:4], n, op[3:0], ra};
    nx_c = {rs, ba, cs, dr, da, 1'b1, wa};
    nx_y = y;
    do @(negedge I_CLK); while (O_CYCLE_END !== 1'b1);
    @(posedge I_CLK);
    a = (rs == SRC_RIN ? internal_register_store[ra] : rs == SRC_ACC ? acc : y) & m;
    b = (ba ? acc : y) & m;
    ci = cs == CIN_ONE || (cs == CIN_CARRY && st[1]);
    t = hw ? {a, a} << n : {16'h0, a[7:0], a[7:0]} << n[2:0];
    case (op)
      OP_MOVE: s = a;
      OP_ADD: s = a + b;
      OP_ADDC: s = a + b + ci;
      OP_SUB: s = a + (~b & m) + 1;
      OP_AND: s = a & b;
      OP_OR: s = a | b;
      OP_XOR: s = a ^ b;
      OP_ROTL: s = hw ? t[31:16] : t[15:8];
      default: s = 17'h0;
    endcase
    repeat (2) @(negedge I_CLK);
    chk(O_COND & pcm, cf(st) & pcm);
    @(negedge I_CLK);
    chk({O_SECOND_HALF, O_Y_OE_N}, 2'b10);
    if (!(op inside {OP_NOP, OP_SETST, OP_RSTST})) chk(O_Y & m, s[15:0] & m);
    pcm = op inside {OP_MOVE, OP_ROTL} ? 12'hf94 : 12'hfff;
    if (op == OP_SETST || op == OP_RSTST) st[4 + ra[1:0]] = op == OP_SETST;
    else if (op != OP_NOP) begin
      st[0] = (s[15:0] & m) == 0;
      st[2] = s[w];
      st[1] = op inside {OP_ADD, OP_ADDC, OP_SUB} && s[w + 1];
      st[3] = (op == OP_SUB ? a[w] != b[w] : op inside {OP_ADD, OP_ADDC} && a[w] == b[w])
        && s[w] != a[w];
    end
    if (da) acc = hw ? s[15:0] : {acc[15:8], s[7:0]};
    if (dr) internal_register_store[wa] = hw ? s[15:0] : {internal_register_store[wa][15:8], s[7:0]};
    lr = s[15:0];
  endtask : exe
  ////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge I_CLK);
    n_errors++;
    complete_run;
  end
  initial begin
    op_t op;
    op_t ops [11];
    bit hw, sp;
    logic [4:0] ra;
    rot_src_t rs;
    ops = '{OP_MOVE, OP_ADD, OP_ADDC, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_ROTL, OP_SETST,
            OP_RSTST, OP_NOP};
    nx_i = 16'h0;
    nx_c = '0;
    nx_y = 16'h0;
    acc = 16'h0;
    st = 8'h00;
    pcm = 12'hfff;
    void'($urandom(32'h6cf4));
    repeat (10) @(posedge I_CLK);
    chk({O_Y_OE_N, O_SECOND_HALF, O_CYCLE_END}, 3'b100);
    I_NRST <= 1'b1;
    apb(0, `REG_CTRL_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1, `REG_CTRL_OFS, 32'h1);
    for (int i = 0; i < 32; i++) exe(OP_MOVE, 1, 0, SRC_LATCH, 0, CIN_ZERO, 0, 1, 0, 5'(i),
                                     16'($urandom));
    for (int i = 0; i < 200; i++) begin
      op = ops[$urandom % 11];
      hw = 1'($urandom);
      sp = op inside {OP_NOP, OP_SETST, OP_RSTST};
      ra = sp ? {3'b001, 2'($urandom)} : 5'($urandom);
      rs = rot_src_t'($urandom % 3);
      exe(op, hw, 4'($urandom), rs, 1'($urandom), cin_sel_t'($urandom % 3), !sp && 1'($urandom),
          !sp && 1'($urandom), ra, 5'($urandom), 16'($urandom));
    end
    exe(OP_XOR, 1, 0, SRC_RIN, 1, CIN_ZERO, 0, 0, 5'd31, 5'd0, 16'($urandom));
    apb(1, `REG_CTRL_OFS, 32'h0);
    apb(1, `REG_STAT_OFS, 32'hff);
    apb(0, `REG_STAT_OFS, 32'h0);
    chk(rd, st);
    apb(0, `REG_ACCUM_OFS, 32'h0);
    chk(rd, acc);
    apb(0, `REG_RESULT_OFS, 32'h0);
    chk(rd, lr);
    apb(0, 12'h010, 32'h0);
    chk({er, rd}, 33'h100000000);
    complete_run;
  end
endmodule : alu_slice_tb
